/* File: include/cid_pkg.sv */
// Constants, types and length checks for the instruction decoder.
// Assumes a 16-bit core whose fetch unit hands over aligned 32-bit words.
package cid_pkg;

   // ----------------------------------------------------------------
   // Instruction classes
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      CL_NONE, CL_ADD, CL_SUB, CL_PRODUCT, CL_QUOT_SHORT, CL_QUOT_LONG,
      CL_INVERT, CL_TWOS, CL_LOGIC, CL_BIT_WRITE, CL_BIT_COPY, CL_BIT_LOGIC,
      CL_BIT_CMP, CL_MASKED_BYTE, CL_CMP, CL_CMP_STEP, CL_NORM_COUNT,
      CL_SHIFT, CL_MOVE, CL_BYTE_EXTEND, CL_JUMP, CL_BRANCH_BIT, CL_CALL,
      CL_PUSH_CALL, CL_TRAP, CL_PUSH_POP, CL_CTX_SWITCH, CL_RETURN,
      CL_SYSTEM, CL_LEGACY_SLEEP, CL_PREFIX, CL_COPRO
   } cid_class_t;

   // Output slot state
   typedef enum logic {S_EMPTY, S_FULL} cid_state_t;

   // ----------------------------------------------------------------
   // Table entry layout
   // ----------------------------------------------------------------
   localparam int ENT_W       = 9;   // Entry width
   localparam int ENT_CLS_LSB = 0;   // Class field
   localparam int ENT_LEN_BIT = 5;   // Set for four-byte form
   localparam int ENT_VAR_LSB = 6;   // Variant field, 3 bits
   localparam int VAR_BYTE    = 0;   // Byte width
   localparam int VAR_ALT     = 1;   // Carry/unsigned/zero/step2/update
   localparam int VAR_SUB     = 2;   // Increment/on-clear/sub-operation
   localparam int TBL_DEPTH   = 256; // One entry per opcode byte

   // ----------------------------------------------------------------
   // Fetch word fields
   // ----------------------------------------------------------------
   localparam int OPC_LSB   = 0;     // Opcode byte
   localparam int REGA_LSB  = 12;    // First register field
   localparam int REGB_LSB  = 8;     // Second register field
   localparam int TRAP_LSB  = 9;     // Trap number, 7 bits
   localparam int EXT_LSB   = 16;    // Extension half word
   localparam int OVRN_LSB  = 12;    // Prefix count field, 2 bits

   // Shift codes
   localparam logic [2:0] SH_LSL   = 3'h0;
   localparam logic [2:0] SH_LSR   = 3'h1;
   localparam logic [2:0] SH_ROTL  = 3'h2;
   localparam logic [2:0] SH_ROTR  = 3'h3;
   localparam logic [2:0] SH_SIGNR = 3'h4;

   // Reset values
   localparam logic [2:0] OVR_CNT_RST = 3'h0;

   // ----------------------------------------------------------------
   // Legal length per class
   // ----------------------------------------------------------------
   function automatic logic cid_len_ok(input cid_class_t c, input logic len4);
      unique case (c)
         CL_PRODUCT, CL_QUOT_SHORT, CL_QUOT_LONG, CL_INVERT, CL_TWOS,
         CL_BIT_WRITE, CL_NORM_COUNT, CL_SHIFT, CL_TRAP, CL_PUSH_POP,
         CL_RETURN:
            cid_len_ok = !len4;
         CL_BIT_COPY, CL_BIT_LOGIC, CL_BIT_CMP, CL_MASKED_BYTE, CL_JUMP,
         CL_BRANCH_BIT, CL_CALL, CL_PUSH_CALL, CL_CTX_SWITCH,
         CL_LEGACY_SLEEP, CL_COPRO:
            cid_len_ok = len4;
         CL_NONE:
            cid_len_ok = 1'b0;
         default:
            cid_len_ok = 1'b1;
      endcase
   endfunction

endpackage

/* File: include/cid_tbl_if.sv */
// Lookup and load path between decoder and opcode table.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface cid_tbl_if;
   import cid_pkg::*;
   logic [7:0]       rd_addr;  // Opcode being looked up
   logic [ENT_W-1:0] rd_entry; // Entry for that opcode
   logic             wr_en;    // Load strobe
   logic [7:0]       wr_addr;  // Load opcode
   logic [ENT_W-1:0] wr_data;  // Load entry
   modport decoder (output rd_addr, wr_en, wr_addr, wr_data, input rd_entry);
   modport table_side (input rd_addr, wr_en, wr_addr, wr_data, output rd_entry);
endinterface

/* File: src/cid_decoder.sv */
// Instruction decoder: classifies each fetched word, checks its length
// and drives per-class control to the datapath.
// Assumes fetch and execute are logic on the same clock.
`timescale 1ns/10ps
module cid_decoder
   import cid_pkg::*;
(
   input  wire logic             I_CLOCK,        // Core clock, 200 MHz
   input  wire logic             I_RST,          // Synchronous reset, high
   input  wire logic             I_FETCH_VALID,  // Fetch word offered
   input  wire logic [31:0]      I_FETCH_WORD,   // Opcode in low byte
   output logic                  O_FETCH_READY,  // Decoder takes a word
   input  wire logic             I_EXEC_READY,   // Execute takes result
   input  wire logic             I_TBL_WE,       // Table load strobe
   input  wire logic [7:0]       I_TBL_ADDR,     // Table load opcode
   input  wire logic [ENT_W-1:0] I_TBL_DATA,     // Table load entry
   output logic                  O_DEC_VALID,    // Result valid
   output logic [4:0]            O_CLASS,        // Instruction class
   output logic [2:0]            O_VARIANT,      // Raw variant bits
   output logic                  O_LEN4,         // Four-byte form
   output logic                  O_ILLEGAL,      // Unknown, bad length or bad shift code
   output logic                  O_BYTE_OP,      // Byte width
   output logic                  O_WITH_CARRY,   // Carry-in used
   output logic                  O_SIGNED,       // Signed arithmetic/extend
   output logic                  O_STEP_UP,      // Step increments
   output logic                  O_STEP_TWO,     // Step by two
   output logic [2:0]            O_SHIFT_CODE,   // Shift kind
   output logic                  O_BRANCH_ON_SET,// Branch when bit set
   output logic                  O_BIT_UPDATE,   // Tested bit rewritten
   output logic                  O_PUSH_FIRST,   // Push before main action
   output logic                  O_POP_REG,      // Return pops register
   output logic                  O_NO_EFFECT,    // Valid but inert
   output logic                  O_COPRO,        // Coprocessor operation
   output logic                  O_PAGE_OVR,     // Page override applies
   output logic                  O_REG_OVR,      // Register override applies
   output logic [3:0]            O_REG_A,        // First register number
   output logic [3:0]            O_REG_B,        // Second register number
   output logic [6:0]            O_TRAP_NUM,     // Vector number
   output logic [15:0]           O_OPERAND       // Extension, zero if short
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      cid_state_t slot;       // Output slot
      logic       ready;      // Fetch ready
      cid_class_t cls;        // Class
      logic [2:0] variant;    // Variant bits
      logic       len4;       // Length
      logic       illegal;    // Rejected
      logic       byte_op;    // Byte width
      logic       carry;      // With carry
      logic       sgn;        // Signed
      logic       step_up;    // Increment
      logic       step_two;   // Step by two
      logic [2:0] shift;      // Shift kind
      logic       on_set;     // Branch on set
      logic       bit_upd;    // Bit update
      logic       push_first; // Push first
      logic       pop_reg;    // Pop on return
      logic       no_effect;  // Inert
      logic       copro;      // Coprocessor
      logic       page_ovr;   // Page override
      logic       reg_ovr;    // Register override
      logic [2:0] ovr_cnt;    // Instructions left in sequence
      logic       ovr_reg_en; // Sequence includes registers
      logic [3:0] reg_a;      // Register A
      logic [3:0] reg_b;      // Register B
      logic [6:0] trap;       // Trap number
      logic [15:0] operand;   // Extension half word
   } cid_dec_state_t;

   cid_dec_state_t st_reg;  // Registered state
   cid_dec_state_t st_next; // Next state

   // ----------------------------------------------------------------
   // Opcode table
   // ----------------------------------------------------------------
   cid_tbl_if tbl ();

   assign tbl.rd_addr = I_FETCH_WORD[OPC_LSB +: 8];
   assign tbl.wr_en   = I_TBL_WE;
   assign tbl.wr_addr = I_TBL_ADDR;
   assign tbl.wr_data = I_TBL_DATA;

   cid_opcode_table u_cid_opcode_table (
      .i_clk (I_CLOCK),
      .i_rst (I_RST),
      .tbl   (tbl.table_side)
   );

   // Entry fields of the offered opcode
   cid_class_t tbl_cls;  // Class from table
   logic       tbl_len4; // Length from table
   logic [2:0] tbl_var;  // Variant from table
   logic       take;     // Word accepted this cycle

   assign tbl_cls  = cid_class_t'(tbl.rd_entry[ENT_CLS_LSB +: 5]);
   assign tbl_len4 = tbl.rd_entry[ENT_LEN_BIT];
   assign tbl_var  = tbl.rd_entry[ENT_VAR_LSB +: 3];
   assign take     = I_FETCH_VALID && st_reg.ready;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      unique case (st_reg.slot)
         S_EMPTY: begin
            if (take) begin
               st_next.slot = S_FULL;
            end
         end
         S_FULL: begin
            // Result held until execute takes it
            if (I_EXEC_READY) begin
               st_next.slot = S_EMPTY;
            end
         end
      endcase
      st_next.ready = (st_next.slot == S_EMPTY);

      if (take) begin
         // Class and length known before execution
         st_next.cls     = tbl_cls;
         st_next.variant = tbl_var;
         st_next.len4    = tbl_len4;
         st_next.illegal = !cid_len_ok(tbl_cls, tbl_len4);
         st_next.reg_a   = I_FETCH_WORD[REGA_LSB +: 4];
         st_next.reg_b   = I_FETCH_WORD[REGB_LSB +: 4];
         st_next.trap    = (tbl_cls == CL_TRAP) ? I_FETCH_WORD[TRAP_LSB +: 7]
                                                : 7'h00;
         st_next.operand = tbl_len4 ? I_FETCH_WORD[EXT_LSB +: 16] : 16'h0000;

         // Width for word/byte classes
         st_next.byte_op = tbl_var[VAR_BYTE] &&
            (tbl_cls inside {CL_ADD, CL_SUB, CL_LOGIC, CL_INVERT, CL_TWOS,
                             CL_CMP, CL_MOVE, CL_BYTE_EXTEND});
         // Carry variant of add and subtract
         st_next.carry = tbl_var[VAR_ALT] && (tbl_cls inside {CL_ADD, CL_SUB});
         // Signed unless unsigned/zero variant
         st_next.sgn = !tbl_var[VAR_ALT] &&
            (tbl_cls inside {CL_PRODUCT, CL_QUOT_SHORT, CL_QUOT_LONG, CL_BYTE_EXTEND});
         // Compare-and-step direction and amount
         st_next.step_up  = (tbl_cls == CL_CMP_STEP) && tbl_var[VAR_SUB];
         st_next.step_two = (tbl_cls == CL_CMP_STEP) && tbl_var[VAR_ALT];
         // Shift kind; codes above signed right are illegal
         st_next.shift = (tbl_cls == CL_SHIFT) ? tbl_var : SH_LSL;
         if ((tbl_cls == CL_SHIFT) && (tbl_var > SH_SIGNR)) begin
            st_next.illegal = 1'b1;
         end
         // Bit branch polarity and optional bit rewrite
         st_next.on_set  = (tbl_cls == CL_BRANCH_BIT) && !tbl_var[VAR_SUB];
         st_next.bit_upd = (tbl_cls == CL_BRANCH_BIT) && tbl_var[VAR_ALT];
         // Push precedes call or load
         st_next.push_first = tbl_cls inside {CL_PUSH_CALL, CL_CTX_SWITCH};
         // Popping return variant
         st_next.pop_reg   = (tbl_cls == CL_RETURN) && tbl_var[VAR_ALT];
         // Legacy sleep is valid but does nothing
         st_next.no_effect = (tbl_cls == CL_LEGACY_SLEEP);
         st_next.copro     = (tbl_cls == CL_COPRO);

         // Page override sequence
         if (tbl_cls == CL_PREFIX) begin
            st_next.page_ovr   = 1'b0;
            st_next.reg_ovr    = 1'b0;
            if (!st_next.illegal) begin
               st_next.ovr_cnt    = 3'(I_FETCH_WORD[OVRN_LSB +: 2]) + 3'h1;
               st_next.ovr_reg_en = tbl_var[VAR_ALT];
            end
         end else if (st_reg.ovr_cnt != 3'h0) begin
            st_next.page_ovr = 1'b1;
            st_next.reg_ovr  = st_reg.ovr_reg_en;
            st_next.ovr_cnt  = st_reg.ovr_cnt - 3'h1;
         end else begin
            st_next.page_ovr = 1'b0;
            st_next.reg_ovr  = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         st_reg         <= '0;
         st_reg.slot    <= S_EMPTY;
         st_reg.ready   <= 1'b1;
         st_reg.ovr_cnt <= OVR_CNT_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from the state register
   // ----------------------------------------------------------------
   assign O_FETCH_READY   = st_reg.ready;
   assign O_DEC_VALID     = (st_reg.slot == S_FULL);
   assign O_CLASS         = st_reg.cls;
   assign O_VARIANT       = st_reg.variant;
   assign O_LEN4          = st_reg.len4;
   assign O_ILLEGAL       = st_reg.illegal;
   assign O_BYTE_OP       = st_reg.byte_op;
   assign O_WITH_CARRY    = st_reg.carry;
   assign O_SIGNED        = st_reg.sgn;
   assign O_STEP_UP       = st_reg.step_up;
   assign O_STEP_TWO      = st_reg.step_two;
   assign O_SHIFT_CODE    = st_reg.shift;
   assign O_BRANCH_ON_SET = st_reg.on_set;
   assign O_BIT_UPDATE    = st_reg.bit_upd;
   assign O_PUSH_FIRST    = st_reg.push_first;
   assign O_POP_REG       = st_reg.pop_reg;
   assign O_NO_EFFECT     = st_reg.no_effect;
   assign O_COPRO         = st_reg.copro;
   assign O_PAGE_OVR      = st_reg.page_ovr;
   assign O_REG_OVR       = st_reg.reg_ovr;
   assign O_REG_A         = st_reg.reg_a;
   assign O_REG_B         = st_reg.reg_b;
   assign O_TRAP_NUM      = st_reg.trap;
   assign O_OPERAND       = st_reg.operand;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);

   property p_fixed_two;
      take && tbl_len4 && (tbl_cls inside {CL_PRODUCT, CL_QUOT_SHORT, CL_QUOT_LONG,
         CL_INVERT, CL_TWOS, CL_NORM_COUNT, CL_SHIFT, CL_TRAP, CL_RETURN})
         |=> O_DEC_VALID && O_ILLEGAL;
   endproperty
   a_fixed_two: assert property (p_fixed_two)
      else $error("two-byte class took four");

   property p_fixed_four;
      take && !tbl_len4 && (tbl_cls inside {CL_BIT_COPY, CL_BIT_LOGIC, CL_BIT_CMP,
         CL_MASKED_BYTE, CL_BRANCH_BIT, CL_PUSH_CALL, CL_CTX_SWITCH, CL_COPRO})
         |=> O_ILLEGAL;
   endproperty
   a_fixed_four: assert property
      (p_fixed_four) else $error("four-byte class took two");

   property p_either;
      take && (tbl_cls inside {CL_ADD, CL_SUB, CL_LOGIC, CL_BYTE_EXTEND, CL_PREFIX})
         |=> !O_ILLEGAL && (O_LEN4 == $past(tbl_len4));
   endproperty
   a_either: assert property (p_either)
      else $error("dual-length class rejected");

   property p_carry;
      take && (tbl_cls == CL_SUB) |=> O_WITH_CARRY == $past(tbl_var[VAR_ALT]);
   endproperty
   a_carry: assert property (p_carry)
      else $error("carry variant lost");

   property p_sleep;
      take && (tbl_cls == CL_LEGACY_SLEEP) && tbl_len4
         |=> O_DEC_VALID && O_NO_EFFECT && !O_ILLEGAL;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("legacy sleep not inert");

   property p_step;
      take && (tbl_cls == CL_CMP_STEP)
         |=> (O_STEP_TWO == $past(tbl_var[VAR_ALT])) && (O_STEP_UP == $past(tbl_var[VAR_SUB]));
   endproperty
   a_step: assert property (p_step)
      else $error("step amount wrong");

   property p_sign_shift;
      take && (tbl_cls == CL_SHIFT) && (tbl_var == SH_SIGNR) && !tbl_len4
         |=> (O_SHIFT_CODE == SH_SIGNR) && !O_ILLEGAL;
   endproperty
   a_sign_shift: assert property (p_sign_shift)
      else $error("signed shift misdecoded");

   property p_prefix;
      O_DEC_VALID && (O_CLASS == CL_PREFIX) && !O_ILLEGAL
         |-> (st_reg.ovr_cnt != 3'h0) && !O_PAGE_OVR;
   endproperty
   a_prefix: assert property (p_prefix)
      else $error("prefix opened no sequence");

   property p_push;
      take && (tbl_cls inside {CL_PUSH_CALL, CL_CTX_SWITCH}) |=> O_PUSH_FIRST;
   endproperty
   a_push: assert property (p_push)
      else $error("push order missing");

   property p_unknown;
      take && (tbl_cls == CL_NONE) |=> O_DEC_VALID && O_ILLEGAL;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unloaded opcode accepted");

   property p_hold;
      O_DEC_VALID && !I_EXEC_READY |=> O_DEC_VALID && $stable(O_CLASS) && !O_FETCH_READY;
   endproperty
   a_hold: assert property (p_hold)
      else $error("result dropped while stalled");

   property p_one_operand;
      take && !tbl_len4 && (tbl_cls inside {CL_INVERT, CL_TWOS})
         |=> !O_ILLEGAL && (O_BYTE_OP == O_VARIANT[VAR_BYTE]);
   endproperty
   a_one_operand: assert property (p_one_operand)
      else $error("one-operand width lost");

   property p_logic;
      take && (tbl_cls == CL_LOGIC)
         |=> (O_BYTE_OP == O_VARIANT[VAR_BYTE]) && !O_WITH_CARRY && !O_ILLEGAL;
   endproperty
   a_logic: assert property (p_logic)
      else $error("logic width wrong");

   property p_extend;
      take && (tbl_cls == CL_BYTE_EXTEND) |=> O_SIGNED != O_VARIANT[VAR_ALT];
   endproperty
   a_extend: assert property (p_extend)
      else $error("extension kind wrong");

   property p_bit_branch;
      take && tbl_len4 && (tbl_cls == CL_BRANCH_BIT)
         |=> !O_ILLEGAL && (O_BRANCH_ON_SET != O_VARIANT[VAR_SUB])
             && (O_BIT_UPDATE == O_VARIANT[VAR_ALT]);
   endproperty
   a_bit_branch: assert property (p_bit_branch)
      else $error("bit branch misdecoded");

   property p_pop;
      take && (tbl_cls == CL_RETURN) |=> O_POP_REG == O_VARIANT[VAR_ALT];
   endproperty
   a_pop: assert property (p_pop)
      else $error("return pop variant lost");

   c_prefix: cover property (take && (tbl_cls == CL_PREFIX) ##[2:6] O_PAGE_OVR);
   c_sleep:  cover property (O_DEC_VALID && O_NO_EFFECT);
   c_copro:  cover property (O_DEC_VALID && O_COPRO && O_LEN4 && !O_ILLEGAL);
   c_carry:  cover property (O_DEC_VALID && O_WITH_CARRY && O_BYTE_OP);
   c_step:   cover property (O_DEC_VALID && O_STEP_UP && O_STEP_TWO);

endmodule

/* File: src/cid_opcode_table.sv */
// Loadable opcode table: one class/length/variant entry per opcode.
// Assumes a loader writes it before decoding; unloaded entries read zero.
`timescale 1ns/10ps
module cid_opcode_table
   import cid_pkg::*;
(
   input wire logic  i_clk,  // Core clock
   input wire logic  i_rst,  // Synchronous reset
   cid_tbl_if.table_side tbl // Lookup and load
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [TBL_DEPTH-1:0]            loaded; // Entry written
      logic [TBL_DEPTH-1:0][ENT_W-1:0] mem;    // Entries
   } cid_tbl_state_t;

   cid_tbl_state_t st_reg;  // Registered state
   cid_tbl_state_t st_next; // Next state

   // Load path
   always_comb begin
      st_next = st_reg;
      if (tbl.wr_en) begin
         st_next.mem[tbl.wr_addr]    = tbl.wr_data;
         st_next.loaded[tbl.wr_addr] = 1'b1;
      end
   end

   // Register the state
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Unloaded opcodes look up as class none
   assign tbl.rd_entry = st_reg.loaded[tbl.rd_addr] ? st_reg.mem[tbl.rd_addr]
                                                    : '0;

endmodule

/* File: tb/cid_decoder_tb.sv */
// Self-checking bench for the decoder: loads table entries, fetches words.
// Assumes the execute model in cid_exec_model and a 200 MHz core clock.
`timescale 1ns/10ps
module cid_decoder_tb;
   import cid_pkg::*;
   logic             clk, rst, fv, we, er, rdy, dv, len4, ill, byt, cy, sgn;
   logic             on_set, upd, push, noeff, cop, povr, rovr, sup, stw, pop;
   logic [2:0]       vr;       // Variant out
   logic [3:0]       ra, rb;   // Register fields out
   logic [31:0]      fw;       // Fetch word
   logic [7:0]       ta;       // Table load opcode
   logic [ENT_W-1:0] td;       // Table load entry
   logic [3:0]       stall;    // Execute stall
   logic [4:0]       cls;      // Class out
   logic [2:0]       sh;       // Shift code out
   logic [6:0]       trap;     // Vector out
   logic [15:0]      opnd;     // Operand out
   int               n_fail;   // Mismatches
   int               checks;   // Comparisons

   cid_decoder u_cid_decoder (.I_CLOCK(clk), .I_RST(rst), .I_FETCH_VALID(fv),
      .I_FETCH_WORD(fw), .O_FETCH_READY(rdy), .I_EXEC_READY(er), .I_TBL_WE(we),
      .I_TBL_ADDR(ta), .I_TBL_DATA(td), .O_DEC_VALID(dv), .O_CLASS(cls), .O_VARIANT(vr),
      .O_LEN4(len4), .O_ILLEGAL(ill), .O_BYTE_OP(byt), .O_WITH_CARRY(cy), .O_SIGNED(sgn),
      .O_STEP_UP(sup), .O_STEP_TWO(stw), .O_SHIFT_CODE(sh), .O_BRANCH_ON_SET(on_set),
      .O_BIT_UPDATE(upd), .O_PUSH_FIRST(push), .O_POP_REG(pop), .O_NO_EFFECT(noeff),
      .O_COPRO(cop), .O_PAGE_OVR(povr), .O_REG_OVR(rovr), .O_REG_A(ra), .O_REG_B(rb),
      .O_TRAP_NUM(trap), .O_OPERAND(opnd));
   cid_exec_model u_cid_exec_model (.i_clk(clk), .i_rst(rst), .i_dec_valid(dv),
      .i_stall(stall), .o_exec_ready(er));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      if (n_fail == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic load(input logic [7:0] op, input cid_class_t c, input logic l4,
                       input logic [2:0] v);
      @(posedge clk);
      we <= 1'b1; ta <= op; td <= {v, l4, c};
      @(posedge clk);
      we <= 1'b0;
   endtask
   // Offer a word, hold until taken, return while the result is valid
   task automatic run(input logic [31:0] w);
      int i;
      @(posedge clk);
      fv <= 1'b1; fw <= w;
      i = 0;
      @(negedge clk);
      while (rdy !== 1'b1 && i < 50) begin @(negedge clk); i++; end
      @(posedge clk);
      fv <= 1'b0;
      @(negedge clk);
      while (dv !== 1'b1 && i < 50) begin @(negedge clk); i++; end
      if (i >= 50) begin n_fail++; complete_run(); end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic sc_arith();
      load(8'h10, CL_ADD, 1'b1, 3'h3); run(32'hbeef_0010);
      chk("len4", 16'h1, len4); chk("carry", 16'h1, cy);
      chk("byte", 16'h1, byt); chk("opnd", 16'hbeef, opnd);
      load(8'h11, CL_SUB, 1'b0, 3'h0); run(32'hbeef_0011);
      chk("opnd2", 16'h0, opnd); chk("ill", 16'h0, ill);
   endtask
   task automatic sc_muldiv();
      stall <= 4'h3;
      load(8'h20, CL_PRODUCT, 1'b0, 3'h2); run(32'h0000_0020);
      chk("sgn", 16'h0, sgn); chk("ill", 16'h0, ill);
      load(8'h21, CL_QUOT_SHORT, 1'b0, 3'h0); run(32'h0000_0021);
      chk("sgn2", 16'h1, sgn);
      load(8'h22, CL_QUOT_LONG, 1'b1, 3'h0); run(32'h0000_0022);
      chk("ill4", 16'h1, ill);
      stall <= 4'h0;
   endtask
   task automatic sc_shift();
      for (int k = 0; k < 6; k++) begin
         load(8'h30 + 8'(k), CL_SHIFT, 1'b0, 3'(k)); run({24'h0, 8'h30 + 8'(k)});
         chk("shill", {15'h0, k == 5}, ill);
         if (k < 5) chk("shcode", 16'(k), sh);
      end
   endtask
   task automatic sc_branch();
      load(8'h40, CL_BRANCH_BIT, 1'b1, 3'h6); run(32'h0000_0040);
      chk("onset", 16'h0, on_set); chk("upd", 16'h1, upd);
      load(8'h41, CL_BRANCH_BIT, 1'b0, 3'h0); run(32'h0000_0041);
      chk("bill", 16'h1, ill);
   endtask
   task automatic sc_misc();
      load(8'h50, CL_LEGACY_SLEEP, 1'b1, 3'h0); run(32'h0000_0050);
      chk("noeff", 16'h1, noeff); chk("slill", 16'h0, ill);
      load(8'h51, CL_COPRO, 1'b1, 3'h0); run(32'h0000_0051);
      chk("copro", 16'h1, cop);
      load(8'h52, CL_PUSH_CALL, 1'b1, 3'h0); run(32'h0000_0052);
      chk("push", 16'h1, push);
      load(8'h53, CL_TRAP, 1'b0, 3'h0); run(32'h0000_b453);
      chk("trap", 16'h5a, trap);
      run(32'h0000_00ff);
      chk("unld", 16'h1, ill); chk("cls", 16'h0, cls);
   endtask
   task automatic sc_regs();
      load(8'h70, CL_CMP_STEP, 1'b1, 3'h6); run(32'h1234_a570);
      chk("sup", 16'h1, sup); chk("stw", 16'h1, stw); chk("var", 16'h6, vr);
      load(8'h71, CL_NORM_COUNT, 1'b0, 3'h0); run(32'h0000_a571);
      chk("rega", 16'ha, ra); chk("regb", 16'h5, rb);
      load(8'h72, CL_RETURN, 1'b0, 3'h2); run(32'h0000_0072);
      chk("pop", 16'h1, pop); chk("trap0", 16'h0, trap);
      load(8'h73, CL_BYTE_EXTEND, 1'b1, 3'h3); run(32'h0000_0073);
      chk("ext", 16'h0, sgn); chk("extb", 16'h1, byt);
      load(8'h74, CL_LOGIC, 1'b0, 3'h1); run(32'h0000_0074);
      chk("lgb", 16'h1, byt); chk("lgc", 16'h0, cy);
      load(8'h75, CL_INVERT, 1'b1, 3'h0); run(32'h0000_0075);
      chk("inv4", 16'h1, ill);
      load(8'h76, CL_CTX_SWITCH, 1'b1, 3'h0); run(32'h0000_0076);
      chk("ctx", 16'h1, push);
   endtask
   task automatic sc_prefix();
      load(8'h60, CL_PREFIX, 1'b0, 3'h2); load(8'h61, CL_MOVE, 1'b0, 3'h0);
      run(32'h0000_1060); chk("pfx", 16'h0, povr);
      run(32'h0000_0061); chk("pov1", 16'h1, povr); chk("rov", 16'h1, rovr);
      run(32'h0000_0061); chk("pov2", 16'h1, povr);
      run(32'h0000_0061); chk("pov3", 16'h0, povr);
   endtask

   // ----------------------------------------------------------------
   // Clock and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rst = 1'b1; fv = 1'b0; fw = 32'h0; we = 1'b0; ta = 8'h0; td = '0;
      stall = 4'h0; n_fail = 0; checks = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      sc_arith();
      sc_muldiv();
      sc_shift();
      sc_branch();
      sc_misc();
      sc_regs();
      sc_prefix();
      complete_run();
   end
endmodule

/* File: tb/cid_exec_model.sv */
// Execute-side partner: takes each held decode result after a stall.
// Assumes the decoder holds its result until the cycle that ready is high.
`timescale 1ns/10ps
module cid_exec_model (
   input  wire logic       i_clk,        // Core clock
   input  wire logic       i_rst,        // Synchronous reset
   input  wire logic       i_dec_valid,  // Result offered
   input  wire logic [3:0] i_stall,      // Cycles to wait before taking
   output logic            o_exec_ready  // Result taken at this edge
);
   logic [3:0] wait_reg;  // Cycles the result has been held

   // ----------------------------------------------------------------
   // Stall counter, restarted for each new result
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_dec_valid) begin
         wait_reg <= 4'h0;
      end else if (!o_exec_ready) begin
         wait_reg <= wait_reg + 4'h1;
      end
   end

   // Ready is a level; zero stall takes in the first valid cycle
   assign o_exec_ready = i_dec_valid && (wait_reg >= i_stall);
endmodule
